// ---- logic/ipr_pkg.sv ----
// Constants, types and helpers for the interrupt priority register group
package ipr_pkg;

    // Sizes
    localparam int IPR_NREG = 5;
    localparam int IPR_NSRC = 19;
    localparam int IPR_FW   = 3;

    // Register byte offsets on the bus
    localparam logic [7:0] IPR_OFF_TMR  = 8'h00;
    localparam logic [7:0] IPR_OFF_ADC  = 8'h04;
    localparam logic [7:0] IPR_OFF_TWI  = 8'h08;
    localparam logic [7:0] IPR_OFF_PWX  = 8'h0c;
    localparam logic [7:0] IPR_OFF_PWG  = 8'h10;
    localparam logic [7:0] IPR_OFF_STAT = 8'h14;

    // Field lsb positions inside each register
    localparam int IPR_P_TMR3 = 12;
    localparam int IPR_P_TMR2 = 8;
    localparam int IPR_P_CMP2 = 4;
    localparam int IPR_P_ADC  = 12;
    localparam int IPR_P_UTX  = 8;
    localparam int IPR_P_URX  = 4;
    localparam int IPR_P_SPI  = 0;
    localparam int IPR_P_TWM  = 8;
    localparam int IPR_P_TWS  = 4;
    localparam int IPR_P_NVM  = 0;
    localparam int IPR_P_PG1  = 12;
    localparam int IPR_P_PSM  = 8;
    localparam int IPR_P_EX2  = 4;
    localparam int IPR_P_EX1  = 0;
    localparam int IPR_P_PG4  = 8;
    localparam int IPR_P_PG3  = 4;
    localparam int IPR_P_PG2  = 0;

    // Status register fields
    localparam int IPR_P_SMAX = 0;
    localparam int IPR_P_SOFF = 4;

    // Priority codes
    localparam logic [2:0] IPR_LVL_RST = 3'h4;
    localparam logic [2:0] IPR_LVL_OFF = 3'h0;
    localparam logic [2:0] IPR_LVL_MIN = 3'h1;
    localparam logic [2:0] IPR_LVL_MAX = 3'h7;

    // Implemented bits and reset values, index 0 last
    localparam logic [IPR_NREG-1:0][15:0] IPR_MASK =
        {16'h0777, 16'h7777, 16'h0777, 16'h7777, 16'h7770};
    localparam logic [IPR_NREG-1:0][15:0] IPR_RST =
        {16'h0444, 16'h4444, 16'h0444, 16'h4444, 16'h4440};

    // Bus slave states
    typedef enum logic {IPR_IDLE, IPR_ACK} ipr_bus_e;

    // Priority of every source
    typedef struct packed {
        logic [2:0] third_timer_prio;
        logic [2:0] second_timer_prio;
        logic [2:0] compare_ch2_prio;
        logic [2:0] conversion_done_prio;
        logic [2:0] serial_tx_prio;
        logic [2:0] serial_rx_prio;
        logic [2:0] sync_serial_prio;
        logic [2:0] twowire_master_prio;
        logic [2:0] twowire_slave_prio;
        logic [2:0] flash_write_prio;
        logic [2:0] pulse_gen1_prio;
        logic [2:0] pulse_special_match_prio;
        logic [2:0] ext_irq2_prio;
        logic [2:0] ext_irq1_prio;
        logic [2:0] pulse_gen4_prio;
        logic [2:0] pulse_gen3_prio;
        logic [2:0] pulse_gen2_prio;
    } ipr_prio_s;

    // Source may compete, same order
    typedef struct packed {
        logic third_timer_prio;
        logic second_timer_prio;
        logic compare_ch2_prio;
        logic conversion_done_prio;
        logic serial_tx_prio;
        logic serial_rx_prio;
        logic sync_serial_prio;
        logic twowire_master_prio;
        logic twowire_slave_prio;
        logic flash_write_prio;
        logic pulse_gen1_prio;
        logic pulse_special_match_prio;
        logic ext_irq2_prio;
        logic ext_irq1_prio;
        logic pulse_gen4_prio;
        logic pulse_gen3_prio;
        logic pulse_gen2_prio;
    } ipr_enable_s;

    // Address decode result
    typedef struct packed {
        logic       hit;
        logic       stat;
        logic [2:0] idx;
    } ipr_dec_s;

    // Map a byte address onto a register
    function automatic ipr_dec_s ipr_decode(input logic [7:0] adr);
        ipr_dec_s d;
        d = '{hit: 1'b1, stat: 1'b0, idx: 3'h0};
        case (adr)
            IPR_OFF_TMR:  d.idx = 3'h0;
            IPR_OFF_ADC:  d.idx = 3'h1;
            IPR_OFF_TWI:  d.idx = 3'h2;
            IPR_OFF_PWX:  d.idx = 3'h3;
            IPR_OFF_PWG:  d.idx = 3'h4;
            IPR_OFF_STAT: begin
                d.hit  = 1'b0;
                d.stat = 1'b1;
            end
            default:      d.hit = 1'b0;
        endcase
        return d;
    endfunction : ipr_decode

    // Highest level held by any source
    function automatic logic [2:0] ipr_max_level(input ipr_prio_s p);
        logic [$bits(ipr_prio_s)-1:0] v;
        logic [2:0]                   m;
        v = p;
        m = IPR_LVL_OFF;
        for (int k = 0; k < $bits(ipr_prio_s) / IPR_FW; k++) begin
            if (v[IPR_FW*k +: IPR_FW] > m) begin
                m = v[IPR_FW*k +: IPR_FW];
            end
        end
        return m;
    endfunction : ipr_max_level

endpackage : ipr_pkg

// ---- logic/ipr_field_reg.sv ----
// One 16-bit priority register with byte lanes and masked bits
`timescale 1ns/1ps
module ipr_field_reg
    import ipr_pkg::*;
#(
    parameter logic [15:0] IMPL_MASK = 16'h0000,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Write port
    input  wire logic        wr_en_i,
    input  wire logic [1:0]  sel_i,
    input  wire logic [15:0] wdata_i,
    // Stored value and per-nibble nonzero flags
    output logic      [15:0] q_o,
    output logic      [3:0]  act_o
);

    // Nonzero flags matching the reset value
    localparam logic [3:0] RESET_ACT = {|RESET_VAL[14:12], |RESET_VAL[10:8],
                                        |RESET_VAL[6:4], |RESET_VAL[2:0]};

    logic [15:0] next_q;   // Value after this edge
    logic [3:0]  next_act; // Flags after this edge

    // Lane merge; unimplemented bits never store
    always_comb begin
        next_q = q_o;
        if (wr_en_i && sel_i[0]) begin
            next_q[7:0] = wdata_i[7:0] & IMPL_MASK[7:0];
        end
        if (wr_en_i && sel_i[1]) begin
            next_q[15:8] = wdata_i[15:8] & IMPL_MASK[15:8];
        end
        // Flags follow the new value, so no extra lag
        for (int n = 0; n < 4; n++) begin
            next_act[n] = |next_q[4*n +: IPR_FW];
        end
    end

    // Register only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o   <= RESET_VAL;
            act_o <= RESET_ACT;
        end else begin
            q_o   <= next_q;
            act_o <= next_act;
        end
    end

endmodule : ipr_field_reg

// ---- logic/ipr_level_summary.sv ----
// Registered summary of the configured levels for status reads
`timescale 1ns/1ps
module ipr_level_summary
    import ipr_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Current priorities
    input  wire ipr_prio_s  prio_i,
    // Summary
    output logic      [2:0] max_level_o,
    output logic            any_off_o
);

    logic [2:0] next_max; // Highest level now
    logic       next_off; // Some source at zero

    // Scan all sources
    always_comb begin
        logic [$bits(ipr_prio_s)-1:0] v;
        v        = prio_i;
        next_max = ipr_max_level(prio_i);
        next_off = 1'b0;
        for (int k = 0; k < IPR_NSRC - 2; k++) begin
            if (v[IPR_FW*k +: IPR_FW] == IPR_LVL_OFF) begin
                next_off = 1'b1;
            end
        end
    end

    // Register only; one cycle behind the fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            max_level_o <= IPR_LVL_RST;
            any_off_o   <= 1'b0;
        end else begin
            max_level_o <= next_max;
            any_off_o   <= next_off;
        end
    end

endmodule : ipr_level_summary

// ---- logic/ipr_top.sv ----
// Priority register group with its bus slave
`timescale 1ns/1ps
module ipr_top
    import ipr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Toward arbitration
    output ipr_prio_s        prio_o,
    output ipr_enable_s      src_enabled_o,
    output logic      [2:0]  top_level_o
);

    ////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////

    ipr_bus_e    state;      // Slave state
    ipr_bus_e    next_state; // Slave state next
    logic        next_ack;   // Ack next
    logic [31:0] next_dat;   // Read data next
    ipr_dec_s    dec;        // Decoded address
    logic        req;        // Live request

    logic [IPR_NREG-1:0]       wr_reg; // Write strobe per reg
    logic [IPR_NREG-1:0][15:0] reg_q;  // Stored registers
    logic [IPR_NREG-1:0][3:0]  reg_act;// Nonzero nibbles
    logic                      any_off;// Some source off

    ////////////////////////////////////////////////////////////////
    // Bus slave
    ////////////////////////////////////////////////////////////////

    assign req = wb_cyc_i & wb_stb_i;
    assign dec = ipr_decode(wb_adr_i);

    // Next state, ack and read data
    always_comb begin
        next_state = state;
        next_ack   = 1'b0;
        next_dat   = 32'h0000_0000;
        wr_reg     = '0;
        unique case (state)
            IPR_IDLE: begin
                // Answer any address, mapped or not
                if (req) begin
                    next_state = IPR_ACK;
                    next_ack   = 1'b1;
                    if (!wb_we_i && dec.hit) begin
                        // Upper half always zero
                        next_dat[15:0] = reg_q[dec.idx];
                    end else if (!wb_we_i && dec.stat) begin
                        next_dat[IPR_P_SMAX +: 3] = top_level_o;
                        next_dat[IPR_P_SOFF]      = any_off;
                    end
                end
            end
            IPR_ACK: begin
                // Write lands on the edge that sees ack
                next_state = IPR_IDLE;
                if (req && wb_we_i && dec.hit) begin
                    wr_reg[dec.idx] = 1'b1;
                end
            end
        endcase
    end

    // Register only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state    <= IPR_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            state    <= next_state;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Priority registers
    ////////////////////////////////////////////////////////////////

    // One instance per register; masks drop unused bits
    for (genvar i = 0; i < IPR_NREG; i++) begin : g_reg
        ipr_field_reg #(
            .IMPL_MASK (IPR_MASK[i]),
            .RESET_VAL (IPR_RST[i])
        ) u_reg (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .wr_en_i (wr_reg[i]),
            .sel_i   (wb_sel_i[1:0]),
            .wdata_i (wb_dat_i[15:0]),
            .q_o     (reg_q[i]),
            .act_o   (reg_act[i])
        );
    end

    ////////////////////////////////////////////////////////////////
    // Field layout
    ////////////////////////////////////////////////////////////////

    // Straight from register bits, no lag
    // Timer register
    assign prio_o.third_timer_prio = reg_q[0][IPR_P_TMR3 +: 3];
    assign prio_o.second_timer_prio = reg_q[0][IPR_P_TMR2 +: 3];
    assign prio_o.compare_ch2_prio = reg_q[0][IPR_P_CMP2 +: 3];
    // Converter and serial register
    assign prio_o.conversion_done_prio = reg_q[1][IPR_P_ADC +: 3];
    assign prio_o.serial_tx_prio = reg_q[1][IPR_P_UTX +: 3];
    assign prio_o.serial_rx_prio = reg_q[1][IPR_P_URX +: 3];
    assign prio_o.sync_serial_prio = reg_q[1][IPR_P_SPI +: 3];
    // Two-wire and memory register
    assign prio_o.twowire_master_prio = reg_q[2][IPR_P_TWM +: 3];
    assign prio_o.twowire_slave_prio = reg_q[2][IPR_P_TWS +: 3];
    assign prio_o.flash_write_prio = reg_q[2][IPR_P_NVM +: 3];
    // Pulse and external register
    assign prio_o.pulse_gen1_prio = reg_q[3][IPR_P_PG1 +: 3];
    assign prio_o.pulse_special_match_prio = reg_q[3][IPR_P_PSM +: 3];
    assign prio_o.ext_irq2_prio = reg_q[3][IPR_P_EX2 +: 3];
    assign prio_o.ext_irq1_prio = reg_q[3][IPR_P_EX1 +: 3];
    // Pulse generator register
    assign prio_o.pulse_gen4_prio = reg_q[4][IPR_P_PG4 +: 3];
    assign prio_o.pulse_gen3_prio = reg_q[4][IPR_P_PG3 +: 3];
    assign prio_o.pulse_gen2_prio = reg_q[4][IPR_P_PG2 +: 3];

    ////////////////////////////////////////////////////////////////
    // Enables: a zero code keeps a source out
    ////////////////////////////////////////////////////////////////

    assign src_enabled_o.third_timer_prio = reg_act[0][IPR_P_TMR3/4];
    assign src_enabled_o.second_timer_prio = reg_act[0][IPR_P_TMR2/4];
    assign src_enabled_o.compare_ch2_prio = reg_act[0][IPR_P_CMP2/4];
    assign src_enabled_o.conversion_done_prio = reg_act[1][IPR_P_ADC/4];
    assign src_enabled_o.serial_tx_prio = reg_act[1][IPR_P_UTX/4];
    assign src_enabled_o.serial_rx_prio = reg_act[1][IPR_P_URX/4];
    assign src_enabled_o.sync_serial_prio = reg_act[1][IPR_P_SPI/4];
    assign src_enabled_o.twowire_master_prio = reg_act[2][IPR_P_TWM/4];
    assign src_enabled_o.twowire_slave_prio = reg_act[2][IPR_P_TWS/4];
    assign src_enabled_o.flash_write_prio = reg_act[2][IPR_P_NVM/4];
    assign src_enabled_o.pulse_gen1_prio = reg_act[3][IPR_P_PG1/4];
    assign src_enabled_o.pulse_special_match_prio = reg_act[3][IPR_P_PSM/4];
    assign src_enabled_o.ext_irq2_prio = reg_act[3][IPR_P_EX2/4];
    assign src_enabled_o.ext_irq1_prio = reg_act[3][IPR_P_EX1/4];
    assign src_enabled_o.pulse_gen4_prio = reg_act[4][IPR_P_PG4/4];
    assign src_enabled_o.pulse_gen3_prio = reg_act[4][IPR_P_PG3/4];
    assign src_enabled_o.pulse_gen2_prio = reg_act[4][IPR_P_PG2/4];

    ////////////////////////////////////////////////////////////////
    // Status summary
    ////////////////////////////////////////////////////////////////

    // Highest level: 7 tops, 1 is lowest live level
    ipr_level_summary u_sum (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .prio_i      (prio_o),
        .max_level_o (top_level_o),
        .any_off_o   (any_off)
    );

    ////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [31:0] last_wdat; // Data seen last edge
    logic [2:0]  max_now;   // Level now
    logic        acc_wr;    // Write accepted now

    always_ff @(posedge clk_i) begin
        last_wdat <= wb_dat_i;
    end

    assign max_now = ipr_max_level(prio_o);
    assign acc_wr  = wb_ack_o & req & wb_we_i;

    AST_RESET_LEVEL: assert property (
        $fell(rst_i) |-> (reg_q == IPR_RST))
        else $error("fields not at level 4 after reset");

    AST_UNUSED_ZERO: assert property (
        (reg_q & ~IPR_MASK) == '0)
        else $error("unimplemented bit stored");

    AST_UPPER_ZERO: assert property (
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");

    AST_TMR3_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_TMR && wb_sel_i[1]
        |=> prio_o.third_timer_prio == last_wdat[14:12])
        else $error("timer 3 field misplaced");

    AST_SPI_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_ADC && wb_sel_i[0]
        |=> prio_o.sync_serial_prio == last_wdat[2:0])
        else $error("sync serial field misplaced");

    AST_TWM_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_TWI && wb_sel_i[1]
        |=> prio_o.twowire_master_prio == last_wdat[10:8] ##1 reg_q[2][15:11] == 5'h00)
        else $error("two-wire master field misplaced");

    AST_EX1_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_PWX && wb_sel_i[0]
        |=> prio_o.ext_irq1_prio == last_wdat[2:0])
        else $error("external 1 field misplaced");

    AST_PG4_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_PWG && wb_sel_i[1]
        |=> prio_o.pulse_gen4_prio == last_wdat[10:8])
        else $error("pulse gen 4 field misplaced");

    AST_TMR2_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_TMR && wb_sel_i[1]
        |=> prio_o.second_timer_prio == last_wdat[10:8])
        else $error("timer 2 field misplaced");

    AST_CMP2_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_TMR && wb_sel_i[0]
        |=> prio_o.compare_ch2_prio == last_wdat[6:4])
        else $error("compare 2 field misplaced");

    AST_ADC_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_ADC && wb_sel_i[1]
        |=> prio_o.conversion_done_prio == last_wdat[14:12])
        else $error("conversion field misplaced");

    AST_UTX_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_ADC && wb_sel_i[1]
        |=> prio_o.serial_tx_prio == last_wdat[10:8])
        else $error("serial transmit field misplaced");

    AST_URX_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_ADC && wb_sel_i[0]
        |=> prio_o.serial_rx_prio == last_wdat[6:4])
        else $error("serial receive field misplaced");

    AST_TWS_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_TWI && wb_sel_i[0]
        |=> prio_o.twowire_slave_prio == last_wdat[6:4])
        else $error("two-wire slave field misplaced");

    AST_NVM_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_TWI && wb_sel_i[0]
        |=> prio_o.flash_write_prio == last_wdat[2:0])
        else $error("memory field misplaced");

    AST_PG1_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_PWX && wb_sel_i[1]
        |=> prio_o.pulse_gen1_prio == last_wdat[14:12])
        else $error("pulse gen 1 field misplaced");

    AST_PSM_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_PWX && wb_sel_i[1]
        |=> prio_o.pulse_special_match_prio == last_wdat[10:8])
        else $error("special match field misplaced");

    AST_EX2_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_PWX && wb_sel_i[0]
        |=> prio_o.ext_irq2_prio == last_wdat[6:4])
        else $error("external 2 field misplaced");

    AST_PG3_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_PWG && wb_sel_i[0]
        |=> prio_o.pulse_gen3_prio == last_wdat[6:4])
        else $error("pulse gen 3 field misplaced");

    AST_PG2_FIELD: assert property (
        acc_wr && wb_adr_i == IPR_OFF_PWG && wb_sel_i[0]
        |=> prio_o.pulse_gen2_prio == last_wdat[2:0])
        else $error("pulse gen 2 field misplaced");

    AST_OFF_SOURCE: assert property (
        src_enabled_o.ext_irq1_prio == (prio_o.ext_irq1_prio != IPR_LVL_OFF))
        else $error("zero code not disabling");

    AST_TOP_LEVEL: assert property (
        max_now == IPR_LVL_MAX |=> top_level_o == IPR_LVL_MAX)
        else $error("level 7 not reported");

    AST_MIN_LEVEL: assert property (
        max_now == IPR_LVL_MIN |=> top_level_o == IPR_LVL_MIN)
        else $error("level 1 not reported");

    AST_HOLD: assert property (
        !(|wr_reg) |=> $stable(reg_q))
        else $error("field changed without write");

    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    COV_WRITE: cover property (acc_wr ##1 !wb_ack_o);
    COV_STAT_READ: cover property (wb_ack_o && !wb_we_i && wb_adr_i == IPR_OFF_STAT);
    COV_SRC_OFF: cover property (!src_enabled_o.pulse_gen2_prio);
    COV_TOP7: cover property (top_level_o == IPR_LVL_MAX);

endmodule : ipr_top

// ---- testbench/ipr_top_tb.sv ----
// Self-checking bench for the interrupt priority register group
`timescale 1ns/1ps
module ipr_top_tb
    import ipr_pkg::*;
;
////////////////////////////////////////////////////////////////
// Stimulus and observed signals
logic        clk_i    = 1'b0;
logic        rst_i    = 1'b1;
logic        wb_cyc_i = 1'b0;
logic        wb_stb_i = 1'b0;
logic        wb_we_i  = 1'b0;
logic [7:0]  wb_adr_i = 8'h00;
logic [3:0]  wb_sel_i = 4'h0;
logic [31:0] wb_dat_i = 32'h00000000;
logic [31:0] wb_dat_o;
logic        wb_ack_o;
ipr_prio_s   prio_o;
ipr_enable_s src_enabled_o;
logic [2:0]  top_level_o;
int          failures   = 0;  // Mismatches
int          n_compared = 0;  // Comparisons made
logic [15:0] mdl [5];         // Expected register contents
// Implemented bits of each register, index 0 first
localparam logic [15:0] IMPL [5] = '{16'h7770, 16'h7777, 16'h0777, 16'h7777, 16'h0777};
// Distinct field codes so a swapped field shows up
localparam logic [15:0] PAT  [5] = '{16'h6521, 16'h1357, 16'h7365, 16'h2763, 16'h5172};

// Free-running 100 MHz clock
always #5 clk_i = ~clk_i;

ipr_top ipr_top_i (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .wb_cyc_i      (wb_cyc_i),
    .wb_stb_i      (wb_stb_i),
    .wb_we_i       (wb_we_i),
    .wb_adr_i      (wb_adr_i),
    .wb_sel_i      (wb_sel_i),
    .wb_dat_i      (wb_dat_i),
    .wb_dat_o      (wb_dat_o),
    .wb_ack_o      (wb_ack_o),
    .prio_o        (prio_o),
    .src_enabled_o (src_enabled_o),
    .top_level_o   (top_level_o)
);
////////////////////////////////////////////////////////////////
// Compare tasks, one per kind of result
task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
        failures++;
        $display("Error %s expected %h seen %h", nm, e, g);
    end
endtask : chk_bus

task automatic chk_arb(input string nm, input logic [50:0] e, input logic [50:0] g);
    n_compared++;
    if (g !== e) begin
        failures++;
        $display("Error %s expected %h seen %h", nm, e, g);
    end
endtask : chk_arb

task automatic close_out();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask : close_out
////////////////////////////////////////////////////////////////
// Bus cycle: held until ack is sampled, then released
task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [15:0] d,
                       input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {16'h0000, d};
    // Sampled right after the edge, so the pre-edge ack is seen
    do begin
        @(posedge clk_i);
        n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
        failures++;
        $display("Error ack expected 1 seen %b", wb_ack_o);
    end
endtask : wb_xfer

// Write and update the model for mapped, byte-enabled, implemented bits
task automatic wr(input logic [7:0] adr, input logic [15:0] d, input logic [3:0] sel);
    logic [31:0] rd;
    logic [15:0] bm;
    bm = {{8{sel[1]}}, {8{sel[0]}}};
    wb_xfer(1'b1, adr, d, sel, rd);
    if (adr[1:0] == 2'b00 && adr < 8'h14) begin
        bm = bm & IMPL[adr[4:2]];
        mdl[adr[4:2]] = (mdl[adr[4:2]] & ~bm) | (d & bm);
    end
endtask : wr

task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
    logic [31:0] rd;
    wb_xfer(1'b0, adr, 16'h0000, 4'hf, rd);
    chk_bus($sformatf("read %h", adr), e, rd);
endtask : rd_chk

task automatic rd_all();
    for (int i = 0; i < 5; i++) begin
        rd_chk(8'(4 * i), {16'h0000, mdl[i]});
    end
endtask : rd_all

// Fields in arbitration order, placed by the documented bit positions
function automatic logic [50:0] exp_prio();
    return {mdl[0][14:12], mdl[0][10:8], mdl[0][6:4],
            mdl[1][14:12], mdl[1][10:8], mdl[1][6:4], mdl[1][2:0],
            mdl[2][10:8], mdl[2][6:4], mdl[2][2:0],
            mdl[3][14:12], mdl[3][10:8], mdl[3][6:4], mdl[3][2:0],
            mdl[4][10:8], mdl[4][6:4], mdl[4][2:0]};
endfunction : exp_prio

// Called as a write returns: prio and enables must follow one cycle later, top level one cycle after that
task automatic chk_out();
    logic [50:0] p;
    logic [16:0] en;
    logic [2:0]  mx;
    p  = exp_prio();
    mx = 3'h0;
    for (int k = 0; k < 17; k++) begin
        en[16-k] = (p[50-3*k -: 3] != 3'h0);
        if (p[3*k +: 3] > mx) begin
            mx = p[3*k +: 3];
        end
    end
    @(posedge clk_i);
    chk_arb("prio_o", p, prio_o);
    chk_arb("src_enabled_o", 51'(en), 51'(src_enabled_o));
    @(posedge clk_i);
    chk_arb("top_level_o", 51'(mx), 51'(top_level_o));
endtask : chk_out
////////////////////////////////////////////////////////////////
// Scenarios
task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
        mdl[i] = IMPL[i] & 16'h4444;
    end
    rd_all();
    chk_out();
    rd_chk(8'h14, 32'h00000004);
endtask : t_reset

task automatic t_ones();
    // All ones: unimplemented bits must stay clear
    for (int i = 0; i < 5; i++) begin
        wr(8'(4 * i), 16'hffff, 4'hf);
    end
    rd_all();
    chk_out();
endtask : t_ones

task automatic t_patterns();
    for (int i = 0; i < 5; i++) begin
        wr(8'(4 * i), PAT[i], 4'h3);
        chk_out();
    end
    rd_all();
endtask : t_patterns

task automatic t_levels();
    // Every code on one field, all others disabled
    for (int i = 0; i < 5; i++) begin
        wr(8'(4 * i), 16'h0000, 4'h3);
    end
    for (int c = 0; c < 8; c++) begin
        wr(8'h0c, 16'(c), 4'h3);
        chk_out();
    end
    // Level 7 on one field, every other field off: status shows both
    rd_chk(8'h14, 32'h00000017);
endtask : t_levels

task automatic t_bytes();
    // Each lane alone, then upper lanes that hold nothing
    wr(8'h04, 16'h0000, 4'h1);
    wr(8'h04, 16'hffff, 4'h2);
    wr(8'h04, 16'h0000, 4'hc);
    rd_all();
    chk_out();
endtask : t_bytes

task automatic t_unmapped();
    // Unmapped and misaligned places answer zero and keep nothing
    wr(8'h18, 16'h0000, 4'hf);
    wr(8'h01, 16'h0000, 4'hf);
    wr(8'h14, 16'hffff, 4'hf);
    rd_chk(8'h18, 32'h00000000);
    rd_chk(8'h02, 32'h00000000);
    rd_all();
endtask : t_unmapped

task automatic t_rereset();
    // Reset in mid-run after fields were changed
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
endtask : t_rereset
////////////////////////////////////////////////////////////////
// Main sequence
initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_ones();
    t_patterns();
    t_levels();
    t_bytes();
    t_unmapped();
    t_rereset();
    close_out();
end

// Watchdog: the run needs well under 2000 cycles
initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    close_out();
end

endmodule : ipr_top_tb
